// ==== inc/uart_line_pkg.sv ====
// line control, break timer and pin function constants and types
package uart_line_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register indices; byte address is four times the index
   localparam int          APB_AW          = 12;
   localparam logic [7:0]  IDX_FLOW_MODE   = 8'h46;
   localparam logic [7:0]  IDX_RESUME_CHAR = 8'h47;
   localparam logic [7:0]  IDX_PAUSE_CHAR  = 8'h48;
   localparam logic [7:0]  IDX_LINE_ERR    = 8'h49;
   localparam logic [7:0]  IDX_BREAK_DUR   = 8'h4a;
   localparam logic [7:0]  IDX_DE_TAIL     = 8'h4b;
   localparam logic [7:0]  IDX_PIN_FUNC    = 8'h4c;
   localparam logic [7:0]  IDX_PIN_DIR     = 8'h4d;
   localparam logic [7:0]  IDX_PIN_HIGH    = 8'h4e;
   localparam logic [7:0]  IDX_PIN_LOW     = 8'h4f;
   localparam logic [7:0]  IDX_PIN_STATUS  = 8'h50;

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int          HALF_DUPLEX_BIT = 3;
   localparam int          DE_POL_BIT      = 3;
   localparam int          ERR_LIVE_BIT    = 7;
   localparam int          ERR_STICKY_LSB  = 3;
   localparam int          ERR_OVR_IDX     = 3;
   localparam int          ERR_PAR_IDX     = 2;
   localparam int          ERR_FRM_IDX     = 1;
   localparam int          ERR_BRK_IDX     = 0;
   localparam int          NUM_PINS        = 6;

   ////////////////////////////////////////////////////////////////////////////
   // reset values and special codes
   localparam logic [3:0]  FLOW_RST        = 4'h0;
   localparam logic [7:0]  RESUME_RST      = 8'h11;
   localparam logic [7:0]  PAUSE_RST       = 8'h13;
   localparam logic [15:0] BREAK_RST       = 16'h0000;
   localparam logic [15:0] BREAK_FOREVER   = 16'hffff;
   localparam logic [3:0]  DE_TAIL_RST     = 4'h0;
   localparam logic [3:0]  PIN_FUNC_RST    = 4'h0;
   localparam logic [5:0]  PIN_DIR_RST     = 6'h00;

   ////////////////////////////////////////////////////////////////////////////
   // timing: break counter steps once per millisecond
   localparam int          CLK_PERIOD_NS   = 5;
   localparam int          MS_TICK_NS      = 1_000_000;
   localparam int          MS_TICK_CYCLES  = MS_TICK_NS / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [2:0] {
      FLOW_NONE     = 3'h0,
      FLOW_HW       = 3'h1,
      FLOW_SW       = 3'h2,
      FLOW_ADDR_RX  = 3'h3,
      FLOW_ADDR_RTX = 3'h4
   } flow_mode_t;

   typedef enum logic [2:0] {
      PIN_PLAIN     = 3'h0,
      PIN_RTS_CTS   = 3'h1,
      PIN_DTR_DSR   = 3'h2,
      PIN_DE_TX     = 3'h3,
      PIN_DE_ADDR   = 3'h4
   } pin_func_t;

   typedef struct packed {
      logic overrun;
      logic parity;
      logic frame;
      logic brk;
   } err_events_t;

   typedef struct packed {
      logic       half_duplex;
      flow_mode_t flow_mode;
      logic [7:0] resume_character;
      logic [7:0] pause_character;
   } line_cfg_t;

endpackage : uart_line_pkg

// ==== rtl/uart_line_ctrl.sv ====
// uart line control: flow config, error flags, break timer, driver enable, pins
`timescale 1ns/1ps

// Operation
// - half-duplex bit set: receiver ignores data while transmitter sends
// - flow mode field: none, hardware, software, address rx, address rx and tx
// - programmable resume character, resets to 0x11
// - programmable pause character, resets to 0x13
// - error bit 7 shows live break on receive line
// - error bit 6 latches overrun until the register is read
// - error bit 5 latches parity error until the register is read
// - error bit 4 latches framing error until the register is read
// - error bit 3 latches received break until the register is read
// - nonzero count below all-ones drives break, decremented every millisecond
// - break ends when the count reaches zero, lasting N milliseconds
// - all-ones count gives endless break without counting
// - endless break ends on zero write; other value makes it timed
// - driver enable drops a programmed number of bit times after sending
// - pin function bit 3 picks driver enable polarity, 1 active high
// - pin function 000: all six pins plain inputs or outputs
// - pin function 001: pins 5 and 4 do request/clear handshake
// - pin function 010: pins 3 and 2 do ready/set-ready handshake
// - pin function 011: pin 5 is driver enable while sending
// - pin function 100: pin 5 driver enable only after address match
// - direction bits: 1 output, 0 input, reset zero
// - write-only high register: ones drive output pins high, zeros nothing
// - write-only low register: ones drive output pins low, zeros nothing
module uart_line_ctrl
   import uart_line_pkg::*;
#(
   parameter int unsigned MS_CYCLES = MS_TICK_CYCLES
) (
   input  wire logic                clk,
   input  wire logic                reset_n,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [APB_AW-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   output      logic [31:0]         prdata,
   output      logic                pready,
   output      logic                pslverr,
   input  wire logic                tx_serial,
   input  wire logic                tx_busy,
   output      logic                tx_line,
   input  wire logic                rx_valid,
   output      logic                rx_accept,
   input  wire err_events_t         rx_events,
   input  wire logic                rx_break_level,
   input  wire logic                bit_tick,
   input  wire logic                addr_match,
   input  wire logic                rts_request,
   input  wire logic                dtr_request,
   output      logic                cts_ok,
   output      logic                dsr_ok,
   output      line_cfg_t           line_cfg,
   input  wire logic [NUM_PINS-1:0] pin_in,
   output      logic [NUM_PINS-1:0] pin_out,
   output      logic [NUM_PINS-1:0] pin_oe
);

   localparam int MSW = $clog2(MS_CYCLES + 1);
   localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYCLES - 1);

   if (MS_CYCLES < 2) begin : g_bad_ms
      $error("MS_CYCLES must be at least 2");
   end

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers
   function automatic logic reg_hit(input logic [APB_AW-1:0] a, input logic [7:0] idx);
      return a == {2'b00, idx, 2'b00};
   endfunction : reg_hit

   logic                access;
   logic                done;
   logic                wr_en;
   logic                hit_any;
   logic [15:0]         rd_value;
   logic                pready_reg;
   logic                pslverr_reg;
   logic [31:0]         prdata_reg;
   logic [3:0]          rd_snap_reg;
   logic [3:0]          clr_mask;
   logic [3:0]          err_sticky_reg;
   logic [15:0]         brk_cnt_reg;
   logic [MSW-1:0]      ms_cnt_reg;
   logic                brk_wr;
   logic                brk_timed;
   logic [3:0]          de_tail_reg;
   logic [3:0]          tail_cnt_reg;
   logic                tx_busy_d_reg;
   logic                de_want;
   logic                de_level;
   logic [3:0]          pin_func_reg;
   pin_func_t           pin_func;
   logic [5:0]          pin_dir_reg;
   logic [5:0]          pin_level_reg;
   logic [5:0]          pin_status_reg;
   logic [5:0]          pin_out_next;
   logic [5:0]          pin_oe_next;
   logic                tx_line_reg;
   logic                rx_accept_reg;
   logic                cts_ok_reg;
   logic                dsr_ok_reg;
   logic [5:0]          pin_out_reg;
   logic [5:0]          pin_oe_reg;
   line_cfg_t           line_cfg_reg;

   assign access   = psel & penable;
   assign done     = access & pready_reg;
   assign wr_en    = done & pwrite & ~pslverr_reg;
   assign pin_func = pin_func_t'(pin_func_reg[2:0]);

   ////////////////////////////////////////////////////////////////////////////
   // read mux; reserved and write-only bits read zero
   always_comb begin
      hit_any  = 1'b1;
      rd_value = 16'h0000;
      if (reg_hit(paddr, IDX_FLOW_MODE))
         rd_value = {12'h000, line_cfg_reg.half_duplex, line_cfg_reg.flow_mode};
      else if (reg_hit(paddr, IDX_RESUME_CHAR))
         rd_value = {8'h00, line_cfg_reg.resume_character};
      else if (reg_hit(paddr, IDX_PAUSE_CHAR))
         rd_value = {8'h00, line_cfg_reg.pause_character};
      else if (reg_hit(paddr, IDX_LINE_ERR))
         rd_value = {8'h00, rx_break_level, err_sticky_reg, 3'b000};
      else if (reg_hit(paddr, IDX_BREAK_DUR))
         rd_value = brk_cnt_reg;
      else if (reg_hit(paddr, IDX_DE_TAIL))
         rd_value = {12'h000, de_tail_reg};
      else if (reg_hit(paddr, IDX_PIN_FUNC))
         rd_value = {12'h000, pin_func_reg};
      else if (reg_hit(paddr, IDX_PIN_DIR))
         rd_value = {10'h000, pin_dir_reg};
      else if (reg_hit(paddr, IDX_PIN_STATUS))
         rd_value = {10'h000, pin_status_reg};
      else if (!reg_hit(paddr, IDX_PIN_HIGH) && !reg_hit(paddr, IDX_PIN_LOW))
         hit_any = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: one wait cycle, then pready with registered data
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         rd_snap_reg <= 4'h0;
      end else if (access && !pready_reg) begin
         pready_reg  <= 1'b1;
         pslverr_reg <= ~hit_any;
         prdata_reg  <= {16'h0000, rd_value};
         rd_snap_reg <= (!pwrite && reg_hit(paddr, IDX_LINE_ERR)) ? err_sticky_reg : 4'h0;
      end else begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         rd_snap_reg <= 4'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         line_cfg_reg <= '{half_duplex: 1'b0, flow_mode: FLOW_NONE,
                           resume_character: RESUME_RST, pause_character: PAUSE_RST};
         de_tail_reg  <= DE_TAIL_RST;
         pin_func_reg <= PIN_FUNC_RST;
         pin_dir_reg  <= PIN_DIR_RST;
      end else if (wr_en) begin
         if (reg_hit(paddr, IDX_FLOW_MODE)) begin
            line_cfg_reg.half_duplex <= pwdata[HALF_DUPLEX_BIT];
            line_cfg_reg.flow_mode   <= flow_mode_t'(pwdata[2:0]);
         end
         if (reg_hit(paddr, IDX_RESUME_CHAR))
            line_cfg_reg.resume_character <= pwdata[7:0];
         if (reg_hit(paddr, IDX_PAUSE_CHAR))
            line_cfg_reg.pause_character <= pwdata[7:0];
         if (reg_hit(paddr, IDX_DE_TAIL))
            de_tail_reg <= pwdata[3:0];
         if (reg_hit(paddr, IDX_PIN_FUNC))
            pin_func_reg <= pwdata[3:0];
         if (reg_hit(paddr, IDX_PIN_DIR))
            pin_dir_reg <= pwdata[5:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sticky error flags; only bits already reported are cleared, set wins
   assign clr_mask = (done && !pwrite) ? rd_snap_reg : 4'h0;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         err_sticky_reg <= 4'h0;
      else
         err_sticky_reg <= (err_sticky_reg & ~clr_mask) | rx_events;
   end

   ////////////////////////////////////////////////////////////////////////////
   // break duration counter with millisecond prescaler
   assign brk_wr    = wr_en && reg_hit(paddr, IDX_BREAK_DUR);
   assign brk_timed = (brk_cnt_reg != 16'h0000) && (brk_cnt_reg != BREAK_FOREVER);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         brk_cnt_reg <= BREAK_RST;
         ms_cnt_reg  <= '0;
      end else if (brk_wr) begin
         brk_cnt_reg <= pwdata[15:0];
         ms_cnt_reg  <= '0;
      end else if (brk_timed) begin
         if (ms_cnt_reg == MS_LAST) begin
            ms_cnt_reg  <= '0;
            brk_cnt_reg <= brk_cnt_reg - 16'h0001;
         end else begin
            ms_cnt_reg  <= ms_cnt_reg + MSW'(1);
         end
      end
   end

   // transmit line forced low while a break is pending
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         tx_line_reg <= 1'b1;
      else
         tx_line_reg <= (brk_cnt_reg != 16'h0000) ? 1'b0 : tx_serial;
   end

   ////////////////////////////////////////////////////////////////////////////
   // receive gate for half-duplex
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         rx_accept_reg <= 1'b0;
      else
         rx_accept_reg <= rx_valid & ~(line_cfg_reg.half_duplex & tx_busy);
   end

   ////////////////////////////////////////////////////////////////////////////
   // driver enable tail: counts bit times after the transmitter goes idle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_busy_d_reg <= 1'b0;
         tail_cnt_reg  <= 4'h0;
      end else begin
         tx_busy_d_reg <= tx_busy;
         if (tx_busy)
            tail_cnt_reg <= 4'h0;
         else if (tx_busy_d_reg)
            tail_cnt_reg <= de_tail_reg;
         else if (bit_tick && tail_cnt_reg != 4'h0)
            tail_cnt_reg <= tail_cnt_reg - 4'h1;
      end
   end

   assign de_want  = (tx_busy | (tail_cnt_reg != 4'h0))
                     & ((pin_func != PIN_DE_ADDR) | addr_match);
   assign de_level = pin_func_reg[DE_POL_BIT] ? de_want : ~de_want;

   ////////////////////////////////////////////////////////////////////////////
   // plain pin latch, changed only on output pins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_level_reg <= 6'h00;
      end else if (wr_en && reg_hit(paddr, IDX_PIN_HIGH)) begin
         pin_level_reg <= pin_level_reg | (pwdata[5:0] & pin_dir_reg);
      end else if (wr_en && reg_hit(paddr, IDX_PIN_LOW)) begin
         pin_level_reg <= pin_level_reg & ~(pwdata[5:0] & pin_dir_reg);
      end
   end

   // pin status sampling
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         pin_status_reg <= 6'h00;
      else
         pin_status_reg <= pin_in;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin function overrides on top of plain pins
   always_comb begin
      pin_out_next = pin_level_reg;
      pin_oe_next  = pin_dir_reg;
      case (pin_func)
         PIN_PLAIN: begin
         end
         PIN_RTS_CTS: begin
            pin_out_next[5] = ~rts_request;
            pin_oe_next[5]  = 1'b1;
            pin_oe_next[4]  = 1'b0;
         end
         PIN_DTR_DSR: begin
            pin_out_next[3] = ~dtr_request;
            pin_oe_next[3]  = 1'b1;
            pin_oe_next[2]  = 1'b0;
         end
         PIN_DE_TX, PIN_DE_ADDR: begin
            pin_out_next[5] = de_level;
            pin_oe_next[5]  = 1'b1;
         end
         default: begin
         end
      endcase
   end

   // registered pin and handshake outputs
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_out_reg <= 6'h00;
         pin_oe_reg  <= 6'h00;
         cts_ok_reg  <= 1'b1;
         dsr_ok_reg  <= 1'b1;
      end else begin
         pin_out_reg <= pin_out_next;
         pin_oe_reg  <= pin_oe_next;
         cts_ok_reg  <= (pin_func == PIN_RTS_CTS) ? ~pin_in[4] : 1'b1;
         dsr_ok_reg  <= (pin_func == PIN_DTR_DSR) ? ~pin_in[2] : 1'b1;
      end
   end

   assign prdata    = prdata_reg;
   assign pready    = pready_reg;
   assign pslverr   = pslverr_reg;
   assign tx_line   = tx_line_reg;
   assign rx_accept = rx_accept_reg;
   assign cts_ok    = cts_ok_reg;
   assign dsr_ok    = dsr_ok_reg;
   assign line_cfg  = line_cfg_reg;
   assign pin_out   = pin_out_reg;
   assign pin_oe    = pin_oe_reg;

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_high_write;
      wr_en && reg_hit(paddr, IDX_PIN_HIGH);
   endsequence

   sequence s_err_read;
      done && !pwrite && reg_hit(paddr, IDX_LINE_ERR);
   endsequence

   a_rx_gate_halfdup: assert property (
      line_cfg.half_duplex && tx_busy |=> !rx_accept)
      else $error("receive accepted while sending in half duplex");

   a_resume_char_write: assert property (
      wr_en && reg_hit(paddr, IDX_RESUME_CHAR)
      |=> line_cfg.resume_character == $past(pwdata[7:0]))
      else $error("resume character not stored");

   a_overrun_sticky: assert property (
      rx_events.overrun |=> err_sticky_reg[ERR_OVR_IDX])
      else $error("overrun flag lost");

   a_parity_hold: assert property (
      err_sticky_reg[ERR_PAR_IDX] && !(done && !pwrite && reg_hit(paddr, IDX_LINE_ERR))
      |=> err_sticky_reg[ERR_PAR_IDX])
      else $error("parity flag dropped without a read");

   a_frame_clear_read: assert property (
      s_err_read and !rx_events.frame ##0 rd_snap_reg[ERR_FRM_IDX]
      |=> !err_sticky_reg[ERR_FRM_IDX])
      else $error("frame flag not cleared by read");

   a_break_drive_low: assert property (
      brk_cnt_reg != 16'h0000 |=> !tx_line)
      else $error("tx not held low during break");

   a_break_ms_step: assert property (
      brk_timed && ms_cnt_reg == MS_LAST && !brk_wr
      |=> brk_cnt_reg == $past(brk_cnt_reg) - 16'h0001)
      else $error("break counter did not step");

   a_break_forever: assert property (
      brk_cnt_reg == BREAK_FOREVER && !brk_wr |=> brk_cnt_reg == BREAK_FOREVER)
      else $error("endless break counted down");

   a_tail_start: assert property (
      $fell(tx_busy) && de_tail_reg != 4'h0 |=> tail_cnt_reg == $past(de_tail_reg))
      else $error("driver enable tail not loaded");

   a_plain_dir: assert property (
      pin_func == PIN_PLAIN |=> pin_oe == $past(pin_dir_reg))
      else $error("plain pin direction mismatch");

   a_high_drive: assert property (
      s_high_write ##0 (pwdata[0] && pin_dir_reg[0] && pin_func == PIN_PLAIN)
      ##1 pin_func == PIN_PLAIN |=> pin_out[0])
      else $error("pin not driven high");

endmodule : uart_line_ctrl

// ==== tb/uart_line_control_and_pins_tb_top.sv ====
// self-checking bench for line control registers, flags, break and pins
`timescale 1ns/1ps
module uart_line_control_and_pins_tb_top
   import uart_line_pkg::*;
;
   localparam int unsigned MS = 8;
   logic                clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
   logic                pwrite = 1'b0, tx_serial = 1'b1, tx_busy = 1'b0, rx_valid = 1'b0;
   logic                rx_break_level = 1'b0, bit_tick = 1'b0, addr_match = 1'b0;
   logic                rts_request = 1'b0, dtr_request = 1'b0;
   logic [APB_AW-1:0]   paddr = '0;
   logic [31:0]         pwdata = '0, prdata, rdata;
   logic                pready, pslverr, tx_line, rx_accept, cts_ok, dsr_ok, rerr;
   err_events_t         rx_events = '0;
   line_cfg_t           line_cfg;
   logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe, far_level = '0, far_oe = '0;
   int                  fail_count = 0, checks = 0, low_cycles = 0, base;
   logic [15:0]         rst_tab [9] = '{16'h0000, 16'h0011, 16'h0013, 16'h0000, 16'h0000,
                                        16'h0000, 16'h0000, 16'h0000, 16'h0000};

   ////////////////////////////////////////////////////////////////////////////
   // design, far end, clock and low-time counter
   uart_line_ctrl #(.MS_CYCLES(MS)) dut (
      .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_serial(tx_serial), .tx_busy(tx_busy), .tx_line(tx_line), .rx_valid(rx_valid),
      .rx_accept(rx_accept), .rx_events(rx_events), .rx_break_level(rx_break_level),
      .bit_tick(bit_tick), .addr_match(addr_match), .rts_request(rts_request),
      .dtr_request(dtr_request), .cts_ok(cts_ok), .dsr_ok(dsr_ok), .line_cfg(line_cfg),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
   uart_line_remote far_end (.pin_out(pin_out), .pin_oe(pin_oe), .far_level(far_level),
      .far_oe(far_oe), .pin_in(pin_in));
   always #2.5 clk = ~clk;
   always @(posedge clk) if (tx_line === 1'b0) low_cycles <= low_cycles + 1;

   ////////////////////////////////////////////////////////////////////////////
   // one apb transfer, held until pready, then one idle cycle
   task automatic apb(input logic w, input logic [7:0] idx, input logic [15:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {16'h0000, d};
      @(posedge clk);
      penable <= 1'b1;
      // no cycle count assumed; only the watchdog ends a stuck wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
      end
   endtask : chk

   task automatic results();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results

   ////////////////////////////////////////////////////////////////////////////
   // tests take about 460 cycles; the watchdog allows 20000, over forty times that
   initial begin
      #(20_000 * 5);
      fail_count++;
      results();
   end

   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      // reset values, write-only register reads zero
      for (int i = 0; i < 9; i++) begin
         apb(1'b0, IDX_FLOW_MODE + 8'(i), 16'h0000);
         chk(rdata[15:0], rst_tab[i]);
      end
      // every flow mode code, then reserved bits read back as zero
      for (int m = 0; m < 5; m++) begin
         apb(1'b1, IDX_FLOW_MODE, 16'(m));
         apb(1'b0, IDX_FLOW_MODE, 16'h0000);
         chk(rdata[15:0], 16'(m));
         chk(16'(line_cfg.flow_mode), 16'(m));
      end
      apb(1'b1, IDX_FLOW_MODE, 16'hffff);
      apb(1'b0, IDX_FLOW_MODE, 16'h0000);
      chk(rdata[31:16] | rdata[15:0], 16'h000f);
      apb(1'b1, IDX_RESUME_CHAR, 16'h00a5);
      apb(1'b1, IDX_PAUSE_CHAR, 16'h005a);
      chk({line_cfg.resume_character, line_cfg.pause_character}, 16'ha55a);
      // half duplex blocks receive only while sending
      rx_valid <= 1'b1;
      tx_busy <= 1'b1;
      tick(2);
      chk(16'(rx_accept), 16'h0000);
      tx_busy <= 1'b0;
      tick(2);
      chk(16'(rx_accept), 16'h0001);
      apb(1'b1, IDX_FLOW_MODE, 16'h0000);
      tx_busy <= 1'b1;
      tick(2);
      chk(16'(rx_accept), 16'h0001);
      tx_busy <= 1'b0;
      // each sticky flag alone, cleared by the read returning it
      for (int b = 0; b < 4; b++) begin
         rx_events <= err_events_t'(4'(1 << b));
         @(posedge clk);
         rx_events <= '0;
         apb(1'b0, IDX_LINE_ERR, 16'h0000);
         chk(rdata[15:0], 16'(8 << b));
      end
      rx_break_level <= 1'b1;
      rx_events <= '1;
      @(posedge clk);
      rx_events <= '0;
      apb(1'b0, IDX_LINE_ERR, 16'h0000);
      chk(rdata[15:0], 16'h00f8);
      apb(1'b0, IDX_LINE_ERR, 16'h0000);
      chk(rdata[15:0], 16'h0080);
      rx_break_level <= 1'b0;
      apb(1'b0, IDX_LINE_ERR, 16'h0000);
      chk(rdata[15:0], 16'h0000);
      // timed break, endless break, retimed and stopped
      base = low_cycles;
      apb(1'b1, IDX_BREAK_DUR, 16'h0002);
      tick(MS + 2);
      apb(1'b0, IDX_BREAK_DUR, 16'h0000);
      chk(rdata[15:0], 16'h0001);
      tick(100);
      chk(16'(low_cycles - base), 16'(2 * MS));
      apb(1'b1, IDX_BREAK_DUR, 16'hffff);
      tick(5 * MS);
      apb(1'b0, IDX_BREAK_DUR, 16'h0000);
      chk({rdata[15:1], tx_line}, 16'hfffe);
      apb(1'b1, IDX_BREAK_DUR, 16'h0003);
      tick(3 * MS - 2);
      chk(16'(tx_line), 16'h0000);
      tick(6);
      chk(16'(tx_line), 16'h0001);
      apb(1'b1, IDX_BREAK_DUR, 16'hffff);
      tick(10);
      apb(1'b1, IDX_BREAK_DUR, 16'h0000);
      tick(3);
      chk(16'(tx_line), 16'h0001);
      // plain pins: set and clear touch output pins only
      apb(1'b1, IDX_PIN_DIR, 16'h0003);
      apb(1'b1, IDX_PIN_HIGH, 16'h003f);
      tick(2);
      chk(16'({pin_oe, pin_out}), 16'h00c3);
      apb(1'b1, IDX_PIN_DIR, 16'h003f);
      apb(1'b1, IDX_PIN_LOW, 16'h0001);
      apb(1'b1, IDX_PIN_HIGH, 16'h0020);
      tick(2);
      chk(16'(pin_out), 16'h0022);
      far_oe <= 6'h20;
      apb(1'b1, IDX_PIN_DIR, 16'h000f);
      apb(1'b0, IDX_PIN_STATUS, 16'h0000);
      chk(rdata[15:0], 16'h0012);
      apb(1'b1, 8'h3f, 16'h1234);
      chk(16'(rerr), 16'h0001);
      // driver enable with a two bit-time tail, high then low polarity
      far_oe <= 6'h14;
      apb(1'b1, IDX_PIN_DIR, 16'h002b);
      apb(1'b1, IDX_DE_TAIL, 16'h0002);
      apb(1'b1, IDX_PIN_FUNC, 16'h000b);
      tx_busy <= 1'b1;
      tick(3);
      chk(16'(pin_out[5]), 16'h0001);
      tx_busy <= 1'b0;
      tick(4);
      bit_tick <= 1'b1;
      @(posedge clk);
      bit_tick <= 1'b0;
      tick(2);
      chk(16'(pin_out[5]), 16'h0001);
      bit_tick <= 1'b1;
      @(posedge clk);
      bit_tick <= 1'b0;
      tick(2);
      chk(16'(pin_out[5]), 16'h0000);
      apb(1'b1, IDX_PIN_FUNC, 16'h0003);
      tick(2);
      chk(16'(pin_out[5]), 16'h0001);
      tx_busy <= 1'b1;
      apb(1'b1, IDX_PIN_FUNC, 16'h000c);
      tick(2);
      chk(16'(pin_out[5]), 16'h0000);
      addr_match <= 1'b1;
      tick(3);
      chk(16'(pin_out[5]), 16'h0001);
      tx_busy <= 1'b0;
      // request/clear then ready/set-ready handshakes, pins active low
      apb(1'b1, IDX_PIN_FUNC, 16'h0001);
      rts_request <= 1'b1;
      far_level <= 6'h10;
      tick(3);
      chk(16'({pin_out[5], cts_ok}), 16'h0000);
      rts_request <= 1'b0;
      far_level <= 6'h00;
      tick(3);
      chk(16'({pin_out[5], cts_ok}), 16'h0003);
      apb(1'b1, IDX_PIN_FUNC, 16'h0002);
      dtr_request <= 1'b1;
      far_level <= 6'h04;
      tick(3);
      chk(16'({pin_out[3], dsr_ok}), 16'h0000);
      results();
   end
endmodule : uart_line_control_and_pins_tb_top

// ==== tb/uart_line_remote.sv ====
// far-end pin model: remote equipment on the shared pins, pull-ups elsewhere
`timescale 1ns/1ps
module uart_line_remote
   import uart_line_pkg::*;
(
   input  wire logic [NUM_PINS-1:0] pin_out,
   input  wire logic [NUM_PINS-1:0] pin_oe,
   input  wire logic [NUM_PINS-1:0] far_level,
   input  wire logic [NUM_PINS-1:0] far_oe,
   output      logic [NUM_PINS-1:0] pin_in
);
   // device drive first, then far end, else the input pull-up
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & far_oe & far_level)
                 | (~pin_oe & ~far_oe);
endmodule : uart_line_remote
